// ===== pkg/bssc_params.svh
`ifndef BSSC_PARAMS_SVH
`define BSSC_PARAMS_SVH

// Clock rate and the 0.1 s time base of every programmed time
`define BSSC_CLK_KHZ 40000
`define BSSC_TICK_MS 100

// Register byte offsets
`define BSSC_OFS_CTRL 8'h00
`define BSSC_OFS_BRK_LVL 8'h04
`define BSSC_OFS_BRK_TIME 8'h08
`define BSSC_OFS_BRK_DLY 8'h0C
`define BSSC_OFS_FULL_LOAD 8'h10
`define BSSC_OFS_JOG_SPD 8'h14
`define BSSC_OFS_JOG_CUR 8'h18
`define BSSC_OFS_JOG_LIM 8'h1C
`define BSSC_OFS_KICK_LVL 8'h20
`define BSSC_OFS_KICK_TIME 8'h24
`define BSSC_OFS_STATUS 8'h28

// Control field positions
`define BSSC_CTRL_BRAKE_ON 0
`define BSSC_CTRL_USE_BEN 1
`define BSSC_CTRL_USE_BDIS 2

// Status field positions
`define BSSC_STAT_LIM_HIT 8
`define BSSC_STAT_BRK_ABORT 9

// Reset values
`define BSSC_RST_CTRL 3'h0
`define BSSC_RST_BRK_LVL 9'h064
`define BSSC_RST_BRK_TIME 16'h0032
`define BSSC_RST_BRK_DLY 16'h0005
`define BSSC_RST_FULL_LOAD 11'h00A
`define BSSC_RST_JOG_SPD 4'h0
`define BSSC_RST_JOG_CUR 9'h064
`define BSSC_RST_JOG_LIM 16'h0000
`define BSSC_RST_KICK_LVL 9'h000
`define BSSC_RST_KICK_TIME 16'h000A

// Decay hold after injection: 0.4 s plus about 3.9 ms per amp of full load current
`define BSSC_DECAY_MIN_MS 400
`define BSSC_DECAY_SCALE 15'h00A
`define BSSC_DECAY_SHIFT 8

`endif

// ===== pkg/bssc_pkg.sv
package bssc_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_brk_dly = 3'h1,
    st_brk_inj = 3'h2,
    st_brk_dcy = 3'h3,
    st_jog_kick = 3'h4,
    st_jog_run = 3'h5
  } bssc_state_t;

endpackage

// ===== hw/bssc_tick_div.sv
`timescale 1ns/10ps
module bssc_tick_div #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Time base
  output logic tick_o
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (cnt == W'(DIV - 1)) begin
      cnt <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule

// ===== hw/bssc_down_timer.sv
`timescale 1ns/10ps
module bssc_down_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic load_i,
  input wire logic [15:0] value_i,
  input wire logic tick_i,
  // State
  output logic [15:0] count_o,
  output logic done_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 16'h0000;
    end else if (load_i) begin
      count_o <= value_i;
    end else if (tick_i && count_o != 16'h0000) begin
      count_o <= count_o - 16'h0001;
    end
  end

  assign done_o = (count_o == 16'h0000);
endmodule

// ===== hw/bssc_top.sv
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "bssc_params.svh"
module bssc_top
  import bssc_pkg::*;
#(
  parameter int TICK_CYCLES = `BSSC_TICK_MS * `BSSC_CLK_KHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Start logic status
  input wire logic run_active_i,
  input wire logic stop_cmd_i,
  // Terminal inputs
  input wire logic cmd_src_term_i,
  input wire logic jog_fwd_in_i,
  input wire logic jog_rev_in_i,
  input wire logic brake_en_in_i,
  input wire logic brake_dis_in_i,
  // Gate drive reference
  output logic gate_en_o,
  output logic dc_inject_o,
  output logic jog_rev_o,
  output logic [3:0] jog_speed_o,
  output logic [8:0] current_ref_o,
  output logic guard_running_class_o,
  // Relays
  output logic brake_relay_o,
  output logic jog_relay_o
);

  bssc_state_t state;
  bssc_state_t next_state;

  logic [2:0] ctrl;
  logic [8:0] brk_lvl;
  logic [15:0] brk_time;
  logic [15:0] brk_dly;
  logic [10:0] full_load;
  logic [3:0] jog_spd;
  logic [8:0] jog_cur;
  logic [15:0] jog_lim;
  logic [8:0] kick_lvl;
  logic [15:0] kick_time;
  logic lim_hit_flag;
  logic brk_abort_flag;

  logic req;
  logic hit;
  logic wr;
  logic [31:0] rd_mux;
  logic [31:0] wval;

  logic tick;
  logic tick_clr;
  logic ph_load;
  logic [15:0] ph_val;
  logic ph_done;
  logic lim_load;
  logic lim_done;
  logic [15:0] lim_cnt;

  logic permit;
  logic jog_st;
  logic brk_st;
  logic jog_req;
  logic dir_held;
  logic lim_hit;
  logic jog_rev;
  logic jog_lock;
  logic [14:0] full_load_x10;
  logic [15:0] decay_ticks;

  function automatic logic [31:0] lane(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register bus: one wait state, unmapped offsets answer with err
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & hit & ~wb_ack_o;
  assign wval = lane(rd_mux, wb_dat_i, wb_sel_i);

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `BSSC_OFS_CTRL: rd_mux = {29'h0, ctrl};
      `BSSC_OFS_BRK_LVL: rd_mux = {23'h0, brk_lvl};
      `BSSC_OFS_BRK_TIME: rd_mux = {16'h0, brk_time};
      `BSSC_OFS_BRK_DLY: rd_mux = {16'h0, brk_dly};
      `BSSC_OFS_FULL_LOAD: rd_mux = {21'h0, full_load};
      `BSSC_OFS_JOG_SPD: rd_mux = {28'h0, jog_spd};
      `BSSC_OFS_JOG_CUR: rd_mux = {23'h0, jog_cur};
      `BSSC_OFS_JOG_LIM: rd_mux = {16'h0, jog_lim};
      `BSSC_OFS_KICK_LVL: rd_mux = {23'h0, kick_lvl};
      `BSSC_OFS_KICK_TIME: rd_mux = {16'h0, kick_time};
      `BSSC_OFS_STATUS: rd_mux = {lim_cnt, 6'h0, brk_abort_flag, lim_hit_flag,
                                  jog_lock, jog_rev, jog_relay_o, brake_relay_o,
                                  1'b0, state};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & hit & ~wb_ack_o & ~wb_err_o;
      wb_err_o <= req & ~hit & ~wb_ack_o & ~wb_err_o;
      if (req & ~wb_ack_o & ~wb_err_o) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `BSSC_RST_CTRL;
      brk_lvl <= `BSSC_RST_BRK_LVL;
      brk_time <= `BSSC_RST_BRK_TIME;
      brk_dly <= `BSSC_RST_BRK_DLY;
      full_load <= `BSSC_RST_FULL_LOAD;
      jog_spd <= `BSSC_RST_JOG_SPD;
      jog_cur <= `BSSC_RST_JOG_CUR;
      jog_lim <= `BSSC_RST_JOG_LIM;
      kick_lvl <= `BSSC_RST_KICK_LVL;
      kick_time <= `BSSC_RST_KICK_TIME;
    end else if (wr) begin
      case (wb_adr_i)
        `BSSC_OFS_CTRL: ctrl <= wval[2:0];
        `BSSC_OFS_BRK_LVL: brk_lvl <= wval[8:0];
        `BSSC_OFS_BRK_TIME: brk_time <= wval[15:0];
        `BSSC_OFS_BRK_DLY: brk_dly <= wval[15:0];
        `BSSC_OFS_FULL_LOAD: full_load <= wval[10:0];
        `BSSC_OFS_JOG_SPD: jog_spd <= wval[3:0];
        `BSSC_OFS_JOG_CUR: jog_cur <= wval[8:0];
        `BSSC_OFS_JOG_LIM: jog_lim <= wval[15:0];
        `BSSC_OFS_KICK_LVL: kick_lvl <= wval[8:0];
        `BSSC_OFS_KICK_TIME: kick_time <= wval[15:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_hit_flag <= 1'b0;
      brk_abort_flag <= 1'b0;
    end else begin
      if (jog_st && lim_hit) begin
        lim_hit_flag <= 1'b1;
      end else if (wr && wb_adr_i == `BSSC_OFS_STATUS && wval[`BSSC_STAT_LIM_HIT]) begin
        lim_hit_flag <= 1'b0;
      end
      if (brk_st && state != st_brk_dcy && !permit) begin
        brk_abort_flag <= 1'b1;
      end else if (wr && wb_adr_i == `BSSC_OFS_STATUS && wval[`BSSC_STAT_BRK_ABORT]) begin
        brk_abort_flag <= 1'b0;
      end
    end
  end

  // Time base restarts with each phase, so no phase loses a partial tick
  assign tick_clr = rst_i | ph_load;

  bssc_tick_div #(.DIV(TICK_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rst_i(tick_clr),
    .tick_o(tick)
  );

  bssc_down_timer u_phase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(ph_load),
    .value_i(ph_val),
    .tick_i(tick),
    .count_o(),
    .done_o(ph_done)
  );

  // Reloaded while idle, so each request starts from the full limit
  assign lim_load = (state == st_idle);

  bssc_down_timer u_limit (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(lim_load),
    .value_i(jog_lim),
    .tick_i(tick & jog_st),
    .count_o(lim_cnt),
    .done_o(lim_done)
  );

  // Bigger motors hold the relay longer so the contactor opens little current
  assign full_load_x10 = 15'(full_load) * `BSSC_DECAY_SCALE;
  assign decay_ticks = 16'(`BSSC_DECAY_MIN_MS / `BSSC_TICK_MS)
                     + {9'h000, full_load_x10[14:`BSSC_DECAY_SHIFT]};

  assign permit = (~ctrl[`BSSC_CTRL_USE_BEN] | brake_en_in_i)
                & (~ctrl[`BSSC_CTRL_USE_BDIS] | ~brake_dis_in_i);
  assign jog_st = (state == st_jog_kick) || (state == st_jog_run);
  assign brk_st = (state == st_brk_dly) || (state == st_brk_inj) || (state == st_brk_dcy);
  // Keypad has no path into the request at all
  assign jog_req = (jog_fwd_in_i | jog_rev_in_i)
                 & cmd_src_term_i
                 & (jog_spd != 4'h0)
                 & ~run_active_i & ~jog_lock;
  assign dir_held = jog_rev ? jog_rev_in_i : jog_fwd_in_i;
  assign lim_hit = (jog_lim != 16'h0000) & lim_done;

  always_comb begin
    next_state = state;
    ph_load = 1'b0;
    ph_val = 16'h0000;
    unique case (state)
      st_idle: begin
        if (stop_cmd_i && ctrl[`BSSC_CTRL_BRAKE_ON] && permit) begin
          next_state = st_brk_dly;
          ph_load = 1'b1;
          ph_val = brk_dly;
        end else if (jog_req) begin
          ph_load = 1'b1;
          if (kick_lvl != 9'h000) begin
            next_state = st_jog_kick;
            ph_val = kick_time;
          end else begin
            next_state = st_jog_run;
          end
        end
      end
      st_brk_dly: begin
        if (!permit) begin
          next_state = st_idle;
        end else if (ph_done) begin
          next_state = st_brk_inj;
          ph_load = 1'b1;
          ph_val = brk_time;
        end
      end
      st_brk_inj: begin
        if (!permit) begin
          next_state = st_idle;
        end else if (ph_done) begin
          next_state = st_brk_dcy;
          ph_load = 1'b1;
          ph_val = decay_ticks;
        end
      end
      st_brk_dcy: begin
        if (ph_done) begin
          next_state = st_idle;
        end
      end
      st_jog_kick: begin
        if (!dir_held || lim_hit) begin
          next_state = st_idle;
        end else if (ph_done) begin
          next_state = st_jog_run;
        end
      end
      st_jog_run: begin
        if (!dir_held || lim_hit) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Forward wins when both inputs rise together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jog_rev <= 1'b0;
    end else if (state == st_idle && jog_req) begin
      jog_rev <= ~jog_fwd_in_i;
    end
  end

  // After a limit stop the inputs must be released before a new request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jog_lock <= 1'b0;
    end else if (jog_st && lim_hit) begin
      jog_lock <= 1'b1;
    end else if (!jog_fwd_in_i && !jog_rev_in_i) begin
      jog_lock <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_en_o <= 1'b0;
      dc_inject_o <= 1'b0;
      jog_rev_o <= 1'b0;
      jog_speed_o <= 4'h0;
      current_ref_o <= 9'h000;
      guard_running_class_o <= 1'b0;
      brake_relay_o <= 1'b0;
      jog_relay_o <= 1'b0;
    end else begin
      gate_en_o <= (state == st_brk_inj) || jog_st;
      dc_inject_o <= (state == st_brk_inj);
      jog_rev_o <= jog_st & jog_rev;
      jog_speed_o <= jog_st ? jog_spd : 4'h0;
      unique case (state)
        st_brk_inj: current_ref_o <= brk_lvl;
        st_jog_kick: current_ref_o <= kick_lvl;
        st_jog_run: current_ref_o <= jog_cur;
        default: current_ref_o <= 9'h000;
      endcase
      guard_running_class_o <= jog_st || brk_st;
      brake_relay_o <= brk_st;
      jog_relay_o <= jog_st;
    end
  end

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_enter_kick;
    (state == st_idle) ##1 (state == st_jog_kick);
  endsequence

  sequence s_inject_over;
    (state == st_brk_inj) && ph_done && permit;
  endsequence

  a_brake_level: assert property (
    (state == st_brk_inj) |=> dc_inject_o && current_ref_o == $past(brk_lvl))
    else $error("brake current differs from brake level");

  a_inject_end: assert property (
    s_inject_over |=> (state == st_brk_dcy) ##1 !dc_inject_o)
    else $error("injection did not end at brake time");

  a_delay_dark: assert property (
    (state == st_brk_dly) |=> !gate_en_o && !dc_inject_o)
    else $error("motor powered during brake delay");

  a_jog_source: assert property (
    (state == st_idle) && !cmd_src_term_i |=> !jog_st)
    else $error("slow speed started from non-terminal source");

  a_jog_idle_only: assert property (
    brk_st |=> !jog_st)
    else $error("slow speed entered from a non-idle state");

  a_jog_relay: assert property (
    1'b1 |=> jog_relay_o == $past(jog_st))
    else $error("slow speed relay out of step");

  a_guard_class: assert property (
    jog_st |=> guard_running_class_o)
    else $error("running overload class not selected");

  a_speed_off: assert property (
    (state == st_idle) && jog_spd == 4'h0 |=> !jog_st)
    else $error("slow speed ran with speed off");

  a_limit_stop: assert property (
    jog_st && lim_hit |=> (state == st_idle) ##1 !jog_st)
    else $error("slow speed not stopped at limit");

  a_kick_level: assert property (
    s_enter_kick |=> current_ref_o == $past(kick_lvl))
    else $error("kick level not applied at start");

  a_brake_permit: assert property (
    (state == st_brk_inj) && !permit |=> (state == st_idle) ##1 !dc_inject_o)
    else $error("braking continued without permit");

  a_jog_release: assert property (
    jog_st && !dir_held |=> (state == st_idle) ##1 !jog_relay_o)
    else $error("slow speed kept after input release");

endmodule

// ===== test/bssc_term_model.sv
`timescale 1ns/10ps
module bssc_term_model (
  // Bench requests: {bdis, ben, rev, fwd, src, run}
  input wire logic [5:0] want_i,
  // Terminal pins
  output logic run_active_o,
  output logic cmd_src_term_o,
  output logic jog_fwd_o,
  output logic jog_rev_o,
  output logic brake_en_o,
  output logic brake_dis_o
);
  // Dry contacts, no bounce modelled; bounce is filtered ahead of this block
  assign run_active_o = want_i[0];
  assign cmd_src_term_o = want_i[1];
  assign jog_fwd_o = want_i[2];
  assign jog_rev_o = want_i[3];
  assign brake_en_o = want_i[4];
  assign brake_dis_o = want_i[5];
endmodule

// ===== test/test_bssc_top.sv
`timescale 1ns/10ps
`include "bssc_params.svh"
module test_bssc_top;
  import bssc_pkg::*;
  localparam int TK = 8;
  logic clk_i, rst_i, cyc, stb, we, stop, ack, err, e;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [5:0] w;
  logic run_a, src, jf, jr, ben, bdis, gate_en_o, dc_inject_o, jog_rev_o, guard_running_class_o;
  logic brake_relay_o, jog_relay_o;
  logic [3:0] jog_speed_o;
  logic [8:0] current_ref_o, lvl;
  logic [10:0] amps;
  int fails, checked, cycles, n;
  logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  logic [31:0] rv [10] = '{`BSSC_RST_CTRL, `BSSC_RST_BRK_LVL, `BSSC_RST_BRK_TIME,
    `BSSC_RST_BRK_DLY, `BSSC_RST_FULL_LOAD, `BSSC_RST_JOG_SPD, `BSSC_RST_JOG_CUR,
    `BSSC_RST_JOG_LIM, `BSSC_RST_KICK_LVL, `BSSC_RST_KICK_TIME};

  bssc_term_model i_bssc_term_model (.want_i(w), .run_active_o(run_a), .cmd_src_term_o(src),
    .jog_fwd_o(jf), .jog_rev_o(jr), .brake_en_o(ben), .brake_dis_o(bdis));
  bssc_top #(.TICK_CYCLES(TK)) i_bssc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .run_active_i(run_a),
    .stop_cmd_i(stop), .cmd_src_term_i(src), .jog_fwd_in_i(jf), .jog_rev_in_i(jr),
    .brake_en_in_i(ben), .brake_dis_in_i(bdis), .gate_en_o(gate_en_o),
    .dc_inject_o(dc_inject_o), .jog_rev_o(jog_rev_o), .jog_speed_o(jog_speed_o),
    .current_ref_o(current_ref_o), .guard_running_class_o(guard_running_class_o),
    .brake_relay_o(brake_relay_o), .jog_relay_o(jog_relay_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic test_done;
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk_in(input string nm, input int lo, input int hi, input logic [31:0] got);
    checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      fails++;
      $display("Error %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Classic cycle: hold until ack or err is sampled, then one idle cycle
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic jog_run(input logic rev, input logic [8:0] kl);
    logic [3:0] spd;
    logic [8:0] cur;
    spd = 4'($urandom_range(15, 1));
    cur = 9'($urandom_range(511, 1));
    wb(1, `BSSC_OFS_JOG_SPD, 32'(spd));
    wb(1, `BSSC_OFS_JOG_CUR, 32'(cur));
    wb(1, `BSSC_OFS_KICK_LVL, 32'(kl));
    wb(1, `BSSC_OFS_KICK_TIME, 32'h2);
    w <= rev ? 6'b001010 : 6'b000110;
    repeat (3) @(posedge clk_i);
    chk("jog_relay", 1, jog_relay_o);
    chk("gate_en", 1, gate_en_o);
    chk("jog_dir", 32'(rev), jog_rev_o);
    chk("jog_speed", 32'(spd), jog_speed_o);
    chk("guard_class", 1, guard_running_class_o);
    chk("start_ref", (kl != 0) ? 32'(kl) : 32'(cur), current_ref_o);
    repeat (3 * TK) @(posedge clk_i);
    chk("run_ref", 32'(cur), current_ref_o);
    w <= 6'b000010;
    repeat (3) @(posedge clk_i);
    chk("jog_relay_off", 0, jog_relay_o);
    chk("gate_off", 0, gate_en_o);
  endtask

  initial begin
    {cyc, stb, we, stop, adr, wdat, w, fails, checked, cycles} = '0;
    rst_i = 1'b1;
    void'($urandom(32'hBDE9F171));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      wb(0, ofs[i], 32'h0);
      chk("reset_value", rv[i], q);
    end
    wb(0, 8'h2C, 32'h0);
    chk("unmapped_err", 1, e);
    w <= 6'b000010;
    for (int k = 0; k < 3; k++) begin
      wb(1, `BSSC_OFS_JOG_SPD, (k == 2) ? 32'h0 : 32'h3);
      w <= (k == 0) ? 6'b000100 : (k == 1) ? 6'b000111 : 6'b001010;
      repeat (4) @(posedge clk_i);
      chk("jog_refused", 0, jog_relay_o);
      w <= 6'b000010;
      repeat (2) @(posedge clk_i);
    end
    for (int k = 0; k < 4; k++)
      jog_run(k[0], k[1] ? 9'($urandom_range(511, 1)) : 9'h000);
    wb(1, `BSSC_OFS_JOG_LIM, 32'h3);
    wb(1, `BSSC_OFS_KICK_LVL, 32'h50);
    for (int k = 0; k < 2; k++) begin
      w <= 6'b000110;
      n = 0;
      repeat (3) @(posedge clk_i);
      while (jog_relay_o === 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      chk_in("limit_time", 2 * TK - 4, 3 * TK + 2, n);
      wb(0, `BSSC_OFS_STATUS, 32'h0);
      chk("limit_flag", 1, q[`BSSC_STAT_LIM_HIT]);
      chk("held_locked", 0, jog_relay_o);
      wb(1, `BSSC_OFS_STATUS, 32'h100);
      w <= 6'b000010;
      repeat (2) @(posedge clk_i);
    end
    wb(1, `BSSC_OFS_JOG_LIM, 32'h0);
    lvl = 9'($urandom_range(400, 1));
    amps = 11'($urandom_range(2047, 0));
    wb(1, `BSSC_OFS_BRK_LVL, 32'(lvl));
    wb(1, `BSSC_OFS_FULL_LOAD, 32'(amps));
    wb(1, `BSSC_OFS_BRK_DLY, 32'h2);
    wb(1, `BSSC_OFS_BRK_TIME, 32'h3);
    // Brake disable energized: no braking at all
    wb(1, `BSSC_OFS_CTRL, 32'h5);
    w <= 6'b100010;
    for (int k = 0; k < 3; k++) begin
      stop <= 1'b1;
      @(posedge clk_i);
      stop <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("relay", (k == 0) ? 0 : 1, brake_relay_o);
      chk("gate_in_delay", 0, gate_en_o);
      n = 0;
      while (dc_inject_o !== 1'b1 && n < 100 && k != 0) begin
        @(posedge clk_i);
        n++;
      end
      if (k != 0)
        chk_in("brake_delay", 2 * TK, 2 * TK + 2, n);
      if (k == 1) begin
        chk("brake_ref", 32'(lvl), current_ref_o);
        // Jog request in mid-brake must wait for idle
        w <= 6'b010110;
        n = 0;
        while (dc_inject_o === 1'b1 && n < 100) begin
          @(posedge clk_i);
          n++;
        end
        chk_in("brake_time", 3 * TK + 1, 3 * TK + 3, n);
        chk("jog_in_brake", 0, jog_relay_o);
        n = 0;
        while (brake_relay_o === 1'b1 && n < 1000) begin
          @(posedge clk_i);
          n++;
        end
        chk_in("decay_time", (4 + ((amps * 10) >> 8)) * TK - 2,
          (4 + ((amps * 10) >> 8)) * TK + 2, n);
      end
      if (k == 2) begin
        w <= 6'b000010;
        repeat (3) @(posedge clk_i);
        chk("abort_inject", 0, dc_inject_o);
        chk("abort_relay", 0, brake_relay_o);
        w <= 6'b010010;
        repeat (4 * TK) @(posedge clk_i);
        chk("no_resume", 0, brake_relay_o);
        wb(0, `BSSC_OFS_STATUS, 32'h0);
        chk("abort_flag", 1, q[`BSSC_STAT_BRK_ABORT]);
      end
      wb(1, `BSSC_OFS_CTRL, (k == 0) ? 32'h1 : 32'h3);
      w <= 6'b010010;
      repeat (2) @(posedge clk_i);
    end
    test_done();
  end
endmodule
